// ---- iar_params.svh ----
// Register offsets, field positions and reset values of the remote alias translator.
`ifndef IAR_PARAMS_SVH
`define IAR_PARAMS_SVH
`define IAR_SLOT4_ALIAS_IDX 8'h45
`define IAR_SLOT5_ALIAS_IDX 8'h46
`define IAR_SLOT6_ALIAS_IDX 8'h47
`define IAR_SLOT7_ALIAS_IDX 8'h48
`define IAR_SLOT4_TARGET_IDX 8'hC5
`define IAR_STATUS_IDX 8'hC9
`define IAR_ALIAS_MSB 7
`define IAR_ALIAS_LSB 1
`define IAR_AUTO_ACK_BIT 0
`define IAR_ALIAS_RESET 8'h00
`define IAR_TARGET_RESET 8'h00
`endif

// ---- iar_pkg.sv ----
// Types shared by the remote alias translator.
package iar_pkg;
    typedef struct packed {
        logic valid;
        logic [6:0] addr;
        logic rnw;
    } iar_req_type;
    typedef struct packed {
        logic fwd;
        logic [6:0] addr;
        logic rnw;
        logic [1:0] slot;
    } iar_fwd_type;
    typedef struct packed {
        logic auto_ack;
        logic nack;
    } iar_resp_type;
endpackage

// ---- iar_alias_remap.sv ----
// Address translator for remote target slots 4 to 7 with APB register access.
`timescale 1ns/100ps
`default_nettype none
`include "iar_params.svh"
// Notes on behaviour
// - Each slot holds a 7-bit alias in bits 7:1 of its register and matches incoming addresses against it.
// - A matched transaction has its address replaced by the slot's physical target address.
// - An alias of zero disables its slot so nothing is forwarded through it.
// - With a slot's bit 0 set every write to that target is acknowledged regardless of link or remote answer.
// - After reset all aliases and auto-acknowledge bits are zero.
// - Slot 7's alias register sits at 0x48 with slots 4 to 6 at the three preceding addresses.
// - The configured target address is the one placed in the forwarded transaction.
module iar_alias_remap #(
    parameter int SLOTS = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire iar_pkg::iar_req_type req,
    output iar_pkg::iar_fwd_type fwd,
    output iar_pkg::iar_resp_type resp
);
    // Register file: alias and physical target address of each slot.
    logic [7:0] alias_reg [SLOTS];
    logic [7:0] next_alias_reg [SLOTS];
    logic [6:0] target_reg [SLOTS];
    logic [6:0] next_target_reg [SLOTS];

    // Bus response state.
    logic ack_q;
    logic next_ack_q;
    logic [31:0] next_prdata;
    logic next_pslverr;

    // Request path state.
    iar_pkg::iar_fwd_type next_fwd;
    iar_pkg::iar_resp_type next_resp;
    logic [7:0] last_slot_hits;
    logic [7:0] next_last_slot_hits;

    // Address and request decode.
    logic [SLOTS-1:0] hit;
    logic [SLOTS-1:0] alias_wr;
    logic [SLOTS-1:0] target_wr;
    logic [SLOTS-1:0] alias_rd;
    logic [SLOTS-1:0] target_rd;
    logic access;
    logic access_first;
    logic access_last;
    logic status_rd;
    logic mapped;

    assign access = psel && penable;
    // One wait state lets prdata and pslverr come from flip-flops and still stand
    // in the cycle in which pready is high.
    assign access_first = access && !ack_q;
    assign access_last = access && ack_q;
    assign pready = ack_q;
    // The status word shows which slots matched the most recent request.
    assign status_rd = (paddr == 32'({`IAR_STATUS_IDX, 2'b00}));
    assign mapped = (|alias_rd) || (|target_rd) || status_rd;

    // Per-slot address decode and alias match.
    genvar g;
    generate
        for (g = 0; g < SLOTS; g++)
        begin : g_slot
            // Register indices are not word aligned, so the byte address is four times the index.
            assign alias_wr[g] = access_last && pwrite
                && (paddr == 32'({8'(`IAR_SLOT4_ALIAS_IDX + g), 2'b00}));
            assign target_wr[g] = access_last && pwrite
                && (paddr == 32'({8'(`IAR_SLOT4_TARGET_IDX + g), 2'b00}));
            assign alias_rd[g] = paddr == 32'({8'(`IAR_SLOT4_ALIAS_IDX + g), 2'b00});
            assign target_rd[g] = paddr == 32'({8'(`IAR_SLOT4_TARGET_IDX + g), 2'b00});
            // A zero alias never matches, which keeps address 0 (general call) local.
            assign hit[g] = req.valid
                && (alias_reg[g][`IAR_ALIAS_MSB:`IAR_ALIAS_LSB] != 7'h00)
                && (alias_reg[g][`IAR_ALIAS_MSB:`IAR_ALIAS_LSB] == req.addr);
        end
    endgenerate

    // Writes land only at the edge that completes the transfer.
    always_comb
    begin
        next_alias_reg = alias_reg;
        next_target_reg = target_reg;
        for (int i = 0; i < SLOTS; i++)
        begin
            if (alias_wr[i])
            begin
                next_alias_reg[i] = pwdata[7:0];
            end
            if (target_wr[i])
            begin
                next_target_reg[i] = pwdata[7:1];
            end
        end
    end

    // Every slot starts disabled, so nothing is forwarded until software programs an alias.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < SLOTS; i++)
            begin
                alias_reg[i] <= `IAR_ALIAS_RESET;
                target_reg[i] <= 7'(`IAR_TARGET_RESET);
            end
        end
        else if (clk_en)
        begin
            alias_reg <= next_alias_reg;
            target_reg <= next_target_reg;
        end
    end

    // Read data and the error flag are loaded in the first access cycle.
    always_comb
    begin
        next_ack_q = access_first;
        next_prdata = prdata;
        next_pslverr = 1'b0;
        if (access_first && !pwrite)
        begin
            // Reads of unmapped offsets return zero.
            next_prdata = 32'h0000_0000;
            for (int i = 0; i < SLOTS; i++)
            begin
                if (alias_rd[i])
                begin
                    next_prdata = {24'h00_0000, alias_reg[i]};
                end
                if (target_rd[i])
                begin
                    next_prdata = {24'h00_0000, target_reg[i], 1'b0};
                end
            end
            if (status_rd)
            begin
                next_prdata = {24'h00_0000, last_slot_hits};
            end
        end
        // Unmapped accesses are refused; an unmapped write changes nothing.
        if (access_first && !mapped)
        begin
            next_pslverr = 1'b1;
        end
    end

    // The acknowledge falls again at the completing edge, so every transfer takes
    // exactly one wait state, back-to-back ones included.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ack_q <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (clk_en)
        begin
            ack_q <= next_ack_q;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // The answer is registered, so it follows its request by exactly one cycle.
    always_comb
    begin
        next_fwd = '0;
        next_resp = '0;
        next_last_slot_hits = last_slot_hits;
        // Lowest slot wins if software programs the same alias twice.
        for (int i = SLOTS - 1; i >= 0; i--)
        begin
            if (hit[i])
            begin
                next_fwd.fwd = 1'b1;
                next_fwd.addr = target_reg[i];
                next_fwd.rnw = req.rnw;
                next_fwd.slot = 2'(i);
                // Auto-acknowledge answers writes even while the link is down, so it can hide
                // a dead remote target; it is meant for debugging only.
                next_resp.auto_ack = alias_reg[i][`IAR_AUTO_ACK_BIT] && !req.rnw;
            end
        end
        // Unmatched requests are refused locally, not forwarded or acknowledged.
        next_resp.nack = req.valid && !(|hit);
        if (req.valid)
        begin
            next_last_slot_hits = {{(8 - SLOTS){1'b0}}, hit};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fwd <= '0;
            resp <= '0;
            last_slot_hits <= 8'h00;
        end
        else if (clk_en)
        begin
            fwd <= next_fwd;
            resp <= next_resp;
            last_slot_hits <= next_last_slot_hits;
        end
    end
endmodule
`default_nettype wire

// ---- iar_alias_remap_monitor.sv ----
// Port assertions for the remote alias translator.
`timescale 1ns/100ps
`default_nettype none
module iar_alias_remap_monitor #(
    parameter int SLOTS = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire iar_pkg::iar_req_type req,
    input wire iar_pkg::iar_fwd_type fwd,
    input wire iar_pkg::iar_resp_type resp
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_req_answered: assert property (req.valid && clk_en |=> fwd.fwd != resp.nack)
        else $error("request not answered once");
    chk_idle_quiet: assert property (clk_en && !req.valid |=> !fwd.fwd && !resp.nack)
        else $error("answer without request");
    chk_ack_write: assert property (resp.auto_ack |-> fwd.fwd && !fwd.rnw)
        else $error("auto ack on read or unmatched");
    chk_zero_nack: assert property (req.valid && clk_en && req.addr == 7'h00 |=> resp.nack)
        else $error("zero address matched");
    chk_rnw_kept: assert property (fwd.fwd && $past(clk_en) |-> fwd.rnw == $past(req.rnw)
        && fwd.slot < SLOTS)
        else $error("direction or slot wrong");
    chk_ready_wait: assert property (psel && penable && clk_en && !pready |=> pready)
        else $error("pready not high after one wait state");
    chk_unmapped_err: assert property (psel && penable && !pready && clk_en && paddr == 32'h0
        |=> pslverr && pready)
        else $error("no error on unmapped");
    chk_alias_ok: assert property (psel && penable && paddr == 32'h120 |=> !pslverr)
        else $error("error on alias register");
endmodule
bind iar_alias_remap iar_alias_remap_monitor #(.SLOTS(SLOTS)) mon (.pclk(pclk),
    .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .req(req), .fwd(fwd), .resp(resp));
`default_nettype wire

// ---- iar_i2c_host.sv ----
// Local controller model that issues address events and takes the answers.
`timescale 1ns/100ps
`default_nettype none
module iar_i2c_host (
    input wire logic pclk,
    output var iar_pkg::iar_req_type req,
    input wire iar_pkg::iar_fwd_type fwd,
    input wire iar_pkg::iar_resp_type resp
);
    initial req = '0;
    // The answer stands one cycle only, so it is taken mid-cycle.
    task automatic send(input logic [6:0] a, input logic w, output logic [12:0] got);
        @(posedge pclk);
        req <= '{1'b1, a, w};
        @(posedge pclk);
        req <= '0;
        @(negedge pclk);
        got = {fwd, resp};
    endtask
endmodule
`default_nettype wire

// ---- iar_alias_remap_test.sv ----
// Self-checking bench for the remote alias translator.
`timescale 1ns/100ps
`default_nettype none
module iar_alias_remap_test;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, q;
    logic [12:0] got;
    logic err;
    logic [6:0] bad [3] = '{7'h30, 7'h7F, 7'h00};
    iar_pkg::iar_req_type req;
    iar_pkg::iar_fwd_type fwd;
    iar_pkg::iar_resp_type resp;
    int n_errors = 0;
    int comparisons = 0;
    iar_alias_remap uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req), .fwd(fwd), .resp(resp));
    iar_i2c_host host (.pclk(pclk), .req(req), .fwd(fwd), .resp(resp));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic end_sim();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial
    begin
        #200000;
        n_errors++;
        end_sim();
    end
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        clk_en = 1'b1;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            bus(1'b0, 32'h114 + 4 * s, 32'h0);
            chk(q, 32'h0);
            chk(32'(err), 32'h0);
            bus(1'b1, 32'h114 + 4 * s, 32'({7'h30 + 7'(s), s[0]}));
            bus(1'b1, 32'h314 + 4 * s, 32'({7'h50 + 7'(s), 1'b0}));
            bus(1'b0, 32'h114 + 4 * s, 32'h0);
            chk(q, 32'({7'h30 + 7'(s), s[0]}));
            bus(1'b0, 32'h314 + 4 * s, 32'h0);
            chk(q, 32'({7'h50 + 7'(s), 1'b0}));
        end
        $display("test registers done");
        for (int s = 0; s < 8; s++)
        begin
            host.send(7'h30 + 7'(s / 2), s[0], got);
            chk(32'(got), 32'({1'b1, 7'h50 + 7'(s / 2), s[0], 2'(s / 2), ~s[0] & s[1], 1'b0}));
        end
        bus(1'b0, 32'h324, 32'h0);
        chk(q, 32'h08);
        $display("test remap done");
        bus(1'b1, 32'h114, 32'h01);
        foreach (bad[i])
        begin
            host.send(bad[i], 1'b0, got);
            chk(32'({got[12], got[1:0]}), 32'h1);
        end
        bus(1'b0, 32'h0, 32'h0);
        chk(q, 32'h0);
        chk(32'(err), 32'h1);
        $display("test refusals done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            bus(1'b0, 32'h114 + 4 * s, 32'h0);
            chk(q, 32'h0);
        end
        host.send(7'h31, 1'b0, got);
        chk(32'({got[12], got[1:0]}), 32'h1);
        $display("test reset done");
        end_sim();
    end
endmodule
`default_nettype wire
